//--- hw/dsc_link_if.sv
// bundle between the link-side receiver and the system-side core
`timescale 1ns/10ps
interface dsc_link_if;
	dsc_pkg::dsc_sample_type sample;
	logic [2:0] chan;
	logic tog;
	logic [4:0] cfg;
	modport rx (output sample, output chan, output tog, input cfg);
	modport core (input sample, input chan, input tog, output cfg);
endinterface

//--- hw/dsc_map.svh
// register map, field positions, reset values and counts of the serial port block
`ifndef DSC_MAP_SVH
`define DSC_MAP_SVH
// register indexes; byte address is index times four
`define DSC_IDX_MODE 6'h06
`define DSC_IDX_CLK 6'h07
`define DSC_IDX_PROC 6'h08
`define DSC_IDX_MUTE 6'h09
`define DSC_IDX_STAT 6'h0f
// reset values
`define DSC_RST_CLK 8'h00
`define DSC_RST_PROC 8'h06
`define DSC_RST_MUTE 8'h00
`define DSC_RST_MODE 3'h0
// serial_port_clock_config fields
`define DSC_B_GEN 7
`define DSC_B_PULSE 6
`define DSC_B_POL 5
`define DSC_B_LSB 4
`define DSC_B_RATE16 2
`define DSC_B_FALL 1
`define DSC_B_MASTER 0
// output_processing_config fields
`define DSC_B_TDM16 4
`define DSC_B_INV 3
`define DSC_B_AMUTE 2
`define DSC_B_OSR 1
`define DSC_B_DEEMP 0
// port framing mode field inside its register
`define DSC_MODE_HI 5
`define DSC_MODE_LO 3
// link configuration bundle bits
`define DSC_LC_POL 4
`define DSC_LC_FALL 3
`define DSC_LC_PULSE 2
`define DSC_LC_LSB 1
`define DSC_LC_S16 0
// last bit index of a slot, zero run length, shifts
`define DSC_SLOT_LAST16 5'h0f
`define DSC_SLOT_LAST32 5'h1f
`define DSC_SH16 4'h4
`define DSC_SH32 4'h5
`define DSC_ZERO_RUN 11'h400
`define DSC_SMP_MAX 24'h7fffff
`define DSC_SMP_MIN 24'h800000
`endif

//--- hw/dsc_pkg.sv
// types shared by the serial port block
package dsc_pkg;
	// port framing mode codes, upper codes reserved
	typedef enum logic [2:0] {
		DSC_STEREO = 3'h0,
		DSC_TDM2 = 3'h1,
		DSC_TDM4 = 3'h2,
		DSC_TDM8 = 3'h3,
		DSC_TDM16 = 3'h4
	} dsc_mode_type;
	// receiver states
	typedef enum logic [1:0] {
		DSC_HUNT = 2'h1,
		DSC_RECV = 2'h2
	} dsc_rx_state_type;
	typedef logic [23:0] dsc_sample_type;
endpackage

//--- hw/dsc_rx.sv
// serial slot receiver on the bit clock; hands slot words 0..7 of each frame to the core
`timescale 1ns/10ps
`include "dsc_map.svh"
module dsc_rx (
	input wire logic link_clk_i, // bit clock as seen on the pin
	input wire logic rst_b_i, // system reset, crossed here
	input wire logic data_i, // serial data line
	input wire logic frame_i, // frame clock as seen on the pin
	dsc_link_if.rx lnk // slot words out, configuration in
);
	logic [5:0] cs;
	logic rst_b;
	logic d_p_q, f_p_q, d_n_q, f_n_q;
	logic d_s, f_s, fn, start;
	logic fprev_q;
	logic [4:0] bit_q;
	logic [4:0] last;
	logic [3:0] slot_q;
	logic [31:0] sr_q;
	logic [31:0] sr_d;
	dsc_pkg::dsc_sample_type word;
	dsc_pkg::dsc_rx_state_type st_q;

	// configuration and reset are quasi-static levels from the system side
	dsc_sync #(.W(6)) u_cfg (
		.clk_i(link_clk_i),
		.rst_b_i(1'b1),
		.d_i({rst_b_i, lnk.cfg}),
		.q_o(cs)
	);
	assign rst_b = cs[5];

	// sample on both edges, then pick the active one
	always_ff @(posedge link_clk_i) begin
		d_p_q <= data_i;
		f_p_q <= frame_i;
	end
	always_ff @(negedge link_clk_i) begin
		d_n_q <= data_i;
		f_n_q <= frame_i;
	end

	assign d_s = cs[`DSC_LC_FALL] ? d_n_q : d_p_q;
	assign f_s = cs[`DSC_LC_FALL] ? f_n_q : f_p_q;
	assign fn = f_s ^ cs[`DSC_LC_POL];
	assign start = cs[`DSC_LC_PULSE] ? (fn & ~fprev_q) : (~fn & fprev_q);
	assign last = cs[`DSC_LC_S16] ? `DSC_SLOT_LAST16 : `DSC_SLOT_LAST32;

	always_comb begin
		sr_d = cs[`DSC_LC_LSB] ? {d_s, sr_q[31:1]} : {sr_q[30:0], d_s};
		if (cs[`DSC_LC_LSB]) begin
			word = cs[`DSC_LC_S16] ? {sr_d[31:16], 8'h00} : sr_d[31:8];
		end else begin
			word = cs[`DSC_LC_S16] ? {sr_d[15:0], 8'h00} : sr_d[31:8];
		end
	end

	// slot framing: restart on every frame start
	always_ff @(posedge link_clk_i) begin
		if (!rst_b) begin
			st_q <= dsc_pkg::DSC_HUNT;
			bit_q <= 5'h00;
			slot_q <= 4'h0;
			sr_q <= 32'h0;
			fprev_q <= 1'b0;
		end else begin
			fprev_q <= fn;
			sr_q <= sr_d;
			if (start) begin
				st_q <= dsc_pkg::DSC_RECV;
				bit_q <= 5'h01;
				slot_q <= 4'h0;
			end else begin
				unique case (st_q)
					dsc_pkg::DSC_HUNT: begin
						bit_q <= 5'h00;
					end
					dsc_pkg::DSC_RECV: begin
						if (bit_q == last) begin
							bit_q <= 5'h00;
							slot_q <= slot_q + 4'h1;
						end else begin
							bit_q <= bit_q + 5'h01;
						end
					end
				endcase
			end
		end
	end

	// hand over slots 0..7; the word holds a whole slot, ample for the crossing
	always_ff @(posedge link_clk_i) begin
		if (!rst_b) begin
			lnk.sample <= 24'h0;
			lnk.chan <= 3'h0;
			lnk.tog <= 1'b0;
		end else if (st_q == dsc_pkg::DSC_RECV && !start && bit_q == last && !slot_q[3]) begin
			lnk.sample <= word;
			lnk.chan <= slot_q[2:0];
			lnk.tog <= ~lnk.tog;
		end
	end
endmodule

//--- hw/dsc_sync.sv
// three-stage synchroniser; output moves once stages two and three agree
`timescale 1ns/10ps
module dsc_sync #(
	parameter int W = 1
) (
	input wire logic clk_i, // destination clock
	input wire logic rst_b_i, // synchronous reset, active low
	input wire logic [W-1:0] d_i, // levels from another domain
	output logic [W-1:0] q_o // filtered levels
);
	logic [W-1:0] s1_q;
	logic [W-1:0] s2_q;
	logic [W-1:0] s3_q;

	// plain chain; the first stage feeds only the second
	always_ff @(posedge clk_i) begin
		s1_q <= d_i;
		s2_q <= s1_q;
		s3_q <= s2_q;
	end

	// accept a new level only when it has stood two edges
	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			q_o <= '0;
		end else begin
			for (int i = 0; i < W; i++) begin
				if (s2_q[i] == s3_q[i]) begin
					q_o[i] <= s3_q[i];
				end
			end
		end
	end
endmodule

//--- hw/dsc_top.sv
// serial audio port configuration and per-channel output control
`timescale 1ns/10ps
`include "dsc_map.svh"
module dsc_top #(
	parameter int BCLK_HALF = 2 // system clocks per half bit clock
) (
	input wire logic SYS_CLK_I, // system clock
	input wire logic RST_B_I, // synchronous reset, active low
	input wire logic [7:0] WB_ADR_I, // byte address
	input wire logic [31:0] WB_DAT_I, // write data
	output logic [31:0] WB_DAT_O, // read data
	input wire logic WB_WE_I, // write enable
	input wire logic [3:0] WB_SEL_I, // byte lanes
	input wire logic WB_STB_I, // strobe
	input wire logic WB_CYC_I, // cycle
	output logic WB_ACK_O, // acknowledge
	input wire logic SERIAL_BIT_CLOCK_I, // bit clock pin level
	output logic SERIAL_BIT_CLOCK_O, // bit clock drive
	output logic SERIAL_BIT_CLOCK_OE_O, // bit clock enable
	input wire logic SERIAL_FRAME_CLOCK_I, // frame clock pin level
	output logic SERIAL_FRAME_CLOCK_O, // frame clock drive
	output logic SERIAL_FRAME_CLOCK_OE_O, // frame clock enable
	input wire logic SERIAL_DATA_LINE_I, // serial data
	input wire logic PLL_LOCK_I, // loop locked to frame clock
	output logic [23:0] CHAN_DATA_O, // processed sample
	output logic [2:0] CHAN_NUM_O, // channel minus one
	output logic CHAN_VALID_O, // sample strobe
	output logic [7:0] CHAN_AUTOMUTED_O, // automute state
	output logic OVERSAMPLE_128_O, // oversampling select
	output logic DEEMPH_ON_O // de-emphasis active
);
	logic [7:0] clk_cfg_q;
	logic [7:0] proc_cfg_q;
	logic [7:0] mute_q;
	logic [2:0] mode_q;
	logic ack_q;
	logic [31:0] rdata_q;
	logic wb_req, wb_wr;
	logic [5:0] idx;
	logic master, gen_bit, pol, pulse, slot16, tdm;
	logic [4:0] cfg_q;
	logic [2:0] syn;
	logic tog_s, lock_s, frame_s;
	logic tog_seen_q;
	logic new_smp;

	dsc_link_if lnk();

	// link side receiver on the pin's bit clock
	dsc_rx u_rx (
		.link_clk_i(SERIAL_BIT_CLOCK_I),
		.rst_b_i(RST_B_I),
		.data_i(SERIAL_DATA_LINE_I),
		.frame_i(SERIAL_FRAME_CLOCK_I),
		.lnk(lnk.rx)
	);

	// bus request decode; one wait state then ack
	assign wb_req = WB_CYC_I & WB_STB_I & ~ack_q;
	assign wb_wr = wb_req & WB_WE_I & WB_SEL_I[0];
	assign idx = WB_ADR_I[7:2];

	// ack for one cycle per request, also for unmapped addresses
	always_ff @(posedge SYS_CLK_I) begin
		if (!RST_B_I) begin
			ack_q <= 1'b0;
		end else begin
			ack_q <= wb_req;
		end
	end

	// serial_port_clock_config
	always_ff @(posedge SYS_CLK_I) begin
		if (!RST_B_I) begin
			clk_cfg_q <= `DSC_RST_CLK;
		end else if (wb_wr && idx == `DSC_IDX_CLK) begin
			clk_cfg_q <= WB_DAT_I[7:0];
		end
	end

	// output_processing_config
	always_ff @(posedge SYS_CLK_I) begin
		if (!RST_B_I) begin
			proc_cfg_q <= `DSC_RST_PROC;
		end else if (wb_wr && idx == `DSC_IDX_PROC) begin
			proc_cfg_q <= WB_DAT_I[7:0];
		end
	end

	always_ff @(posedge SYS_CLK_I) begin
		if (!RST_B_I) begin
			mute_q <= `DSC_RST_MUTE;
		end else if (wb_wr && idx == `DSC_IDX_MUTE) begin
			mute_q <= WB_DAT_I[7:0];
		end
	end

	always_ff @(posedge SYS_CLK_I) begin
		if (!RST_B_I) begin
			mode_q <= `DSC_RST_MODE;
		end else if (wb_wr && idx == `DSC_IDX_MODE) begin
			mode_q <= WB_DAT_I[`DSC_MODE_HI:`DSC_MODE_LO];
		end
	end

	// read data registered with ack; unmapped reads return zero
	always_ff @(posedge SYS_CLK_I) begin
		if (!RST_B_I) begin
			rdata_q <= 32'h0;
		end else if (wb_req) begin
			unique case (idx)
				`DSC_IDX_MODE: rdata_q <= {26'h0, mode_q, 3'h0};
				`DSC_IDX_CLK: rdata_q <= {24'h0, clk_cfg_q};
				`DSC_IDX_PROC: rdata_q <= {24'h0, proc_cfg_q};
				`DSC_IDX_MUTE: rdata_q <= {24'h0, mute_q};
				`DSC_IDX_STAT: rdata_q <= {23'h0, lock_s, CHAN_AUTOMUTED_O};
				default: rdata_q <= 32'h0;
			endcase
		end
	end

	assign WB_ACK_O = ack_q;
	assign WB_DAT_O = rdata_q;

	assign OVERSAMPLE_128_O = proc_cfg_q[`DSC_B_OSR];
	assign DEEMPH_ON_O = proc_cfg_q[`DSC_B_DEEMP];

	assign tdm = (mode_q >= dsc_pkg::DSC_TDM2) && (mode_q <= dsc_pkg::DSC_TDM16);
	assign master = clk_cfg_q[`DSC_B_MASTER];
	assign gen_bit = clk_cfg_q[`DSC_B_GEN];
	assign pol = clk_cfg_q[`DSC_B_POL];
	// pulse shape only in multiplexed modes
	assign pulse = tdm & clk_cfg_q[`DSC_B_PULSE];
	// stereo slot length from rate bit
	assign slot16 = tdm ? proc_cfg_q[`DSC_B_TDM16] : clk_cfg_q[`DSC_B_RATE16];

	// configuration for the link side, from flops so the crossing sees clean levels
	always_ff @(posedge SYS_CLK_I) begin
		if (!RST_B_I) begin
			cfg_q <= 5'h00;
		end else begin
			cfg_q <= {pol, clk_cfg_q[`DSC_B_FALL], pulse, clk_cfg_q[`DSC_B_LSB], slot16};
		end
	end
	assign lnk.cfg = cfg_q;

	// pin levels and the slot toggle enter through three stages
	dsc_sync #(.W(3)) u_sync (
		.clk_i(SYS_CLK_I),
		.rst_b_i(RST_B_I),
		.d_i({lnk.tog, PLL_LOCK_I, SERIAL_FRAME_CLOCK_I}),
		.q_o(syn)
	);
	assign tog_s = syn[2];
	assign lock_s = syn[1];
	assign frame_s = syn[0];

	// bit clock generator
	logic gen_on;
	logic bclk_q;
	logic [7:0] div_q;
	logic div_end;
	logic tick;
	logic [3:0] len_sh;
	logic [9:0] frame_len;
	logic [9:0] pos_q;
	logic [9:0] pos_nx;
	logic fprev_q;
	logic fn_s;
	logic start_s;
	logic frame_q;
	logic bclk_oe_q;
	logic frame_oe_q;

	// own bit clock in master or locked generation
	assign gen_on = master | (gen_bit & lock_s);
	assign div_end = div_q == 8'(BCLK_HALF - 1);
	// frame moves on the edge opposite the latch edge
	assign tick = gen_on & div_end & (clk_cfg_q[`DSC_B_FALL] ? ~bclk_q : bclk_q);

	// frame length is slots times slot length, both powers of two
	assign len_sh = (slot16 ? `DSC_SH16 : `DSC_SH32) + (tdm ? {1'b0, mode_q} : 4'h1);
	assign frame_len = 10'h001 << len_sh;
	// wrap on or past the end, so a shorter frame chosen mid-count restarts at once
	assign pos_nx = (pos_q >= frame_len - 10'h001) ? 10'h000 : pos_q + 10'h001;

	// half period divider
	always_ff @(posedge SYS_CLK_I) begin
		if (!RST_B_I || !gen_on) begin
			div_q <= 8'h00;
			bclk_q <= 1'b0;
		end else if (div_end) begin
			div_q <= 8'h00;
			bclk_q <= ~bclk_q;
		end else begin
			div_q <= div_q + 8'h01;
		end
	end

	assign fn_s = frame_s ^ pol;
	assign start_s = pulse ? (fn_s & ~fprev_q) : (~fn_s & fprev_q);

	always_ff @(posedge SYS_CLK_I) begin
		if (!RST_B_I) begin
			fprev_q <= 1'b0;
		end else begin
			fprev_q <= fn_s;
		end
	end

	// as slave, follow the host frame clock
	always_ff @(posedge SYS_CLK_I) begin
		if (!RST_B_I || !gen_on) begin
			pos_q <= 10'h000;
		end else if (!master && start_s) begin
			pos_q <= 10'h000;
		end else if (tick) begin
			pos_q <= pos_nx;
		end
	end

	always_ff @(posedge SYS_CLK_I) begin
		if (!RST_B_I) begin
			frame_q <= 1'b0;
		end else if (tick) begin
			frame_q <= (pulse ? (pos_nx == 10'h000) : (pos_nx >= (frame_len >> 1))) ^ pol;
		end
	end

	// drive the frame clock pin only as master, the bit clock pin whenever the generator runs
	always_ff @(posedge SYS_CLK_I) begin
		if (!RST_B_I) begin
			bclk_oe_q <= 1'b0;
			frame_oe_q <= 1'b0;
		end else begin
			bclk_oe_q <= gen_on;
			frame_oe_q <= master;
		end
	end

	assign SERIAL_BIT_CLOCK_O = bclk_q;
	assign SERIAL_BIT_CLOCK_OE_O = bclk_oe_q;
	assign SERIAL_FRAME_CLOCK_O = frame_q;
	assign SERIAL_FRAME_CLOCK_OE_O = frame_oe_q;

	// new slot word when the synced toggle moves; the word is stable by then
	assign new_smp = tog_s ^ tog_seen_q;
	always_ff @(posedge SYS_CLK_I) begin
		if (!RST_B_I) begin
			tog_seen_q <= 1'b0;
		end else begin
			tog_seen_q <= tog_s;
		end
	end

	// per-channel processing state
	logic [10:0] zrun_q [8];
	dsc_pkg::dsc_sample_type prev_q [8];
	logic [10:0] zrun_nx;
	logic [2:0] ch;
	dsc_pkg::dsc_sample_type x;
	logic [25:0] xs;
	logic [25:0] ps;
	logic [25:0] acc;
	dsc_pkg::dsc_sample_type y;
	dsc_pkg::dsc_sample_type y2;
	logic muted;

	assign ch = lnk.chan;
	assign x = lnk.sample;

	always_comb begin
		if (x != 24'h0) begin
			zrun_nx = 11'h000;
		end else if (zrun_q[ch] == `DSC_ZERO_RUN) begin
			zrun_nx = `DSC_ZERO_RUN;
		end else begin
			zrun_nx = zrun_q[ch] + 11'h001;
		end
	end

	// shaping, inversion and muting; cheap first order shelf stands in for de-emphasis
	always_comb begin
		xs = {{2{x[23]}}, x};
		ps = {{2{prev_q[ch][23]}}, prev_q[ch]};
		acc = (xs << 1) + xs + ps;
		y = proc_cfg_q[`DSC_B_DEEMP] ? acc[25:2] : x;
		// global inversion, saturating the one value with no negative
		if (!proc_cfg_q[`DSC_B_INV]) begin
			y2 = y;
		end else if (y == `DSC_SMP_MIN) begin
			y2 = `DSC_SMP_MAX;
		end else begin
			y2 = 24'h0 - y;
		end
		muted = mute_q[ch] | (proc_cfg_q[`DSC_B_AMUTE] & (zrun_nx == `DSC_ZERO_RUN));
	end

	// run and filter state per channel
	always_ff @(posedge SYS_CLK_I) begin
		if (!RST_B_I) begin
			for (int i = 0; i < 8; i++) begin
				zrun_q[i] <= 11'h000;
				prev_q[i] <= 24'h0;
			end
		end else if (new_smp) begin
			zrun_q[ch] <= zrun_nx;
			prev_q[ch] <= y;
		end
	end

	// automute state follows enable and count
	always_ff @(posedge SYS_CLK_I) begin
		if (!RST_B_I) begin
			CHAN_AUTOMUTED_O <= 8'h00;
		end else begin
			for (int i = 0; i < 8; i++) begin
				CHAN_AUTOMUTED_O[i] <= proc_cfg_q[`DSC_B_AMUTE] & (zrun_q[i] == `DSC_ZERO_RUN);
			end
		end
	end

	// sample output, one strobe per received slot word
	always_ff @(posedge SYS_CLK_I) begin
		if (!RST_B_I) begin
			CHAN_DATA_O <= 24'h0;
			CHAN_NUM_O <= 3'h0;
			CHAN_VALID_O <= 1'b0;
		end else begin
			CHAN_VALID_O <= new_smp;
			if (new_smp) begin
				CHAN_DATA_O <= muted ? 24'h0 : y2;
				CHAN_NUM_O <= ch;
			end
		end
	end
endmodule

//--- sim/dsc_host.sv
// behavioural audio host driving bit clock, frame clock and data
`timescale 1ns/10ps
module dsc_host (
	output logic bclk_o, // bit clock
	output logic frame_o, // frame clock
	output logic data_o, // serial data
	input wire logic fall_i, // latch on falling edge
	input wire logic pol_i, // frame polarity
	input wire logic pulse_i, // pulse frame shape
	input wire logic lsb_i, // lsb first
	input wire logic s16_i, // 16 bit slots
	input wire logic [4:0] nslots_i // slots per frame
);
	logic [31:0] words [0:15];
	initial begin
		bclk_o = 1'b0;
		frame_o = 1'b1;
		data_o = 1'b0;
	end
	// data and frame move on the idle edge, latch edge follows
	task automatic bit1(input logic fr, input logic d);
		frame_o = fr ^ pol_i;
		data_o = d;
		#15 bclk_o = ~fall_i;
		#15 bclk_o = fall_i;
	endtask
	// whole frames; clock stands still outside a burst
	task automatic burst(input int nfr);
		int len;
		int b;
		len = s16_i ? 16 : 32;
		bclk_o = fall_i;
		for (int k = 0; k < 8; k++) bit1(!pulse_i, ~data_o);
		for (int f = 0; f < nfr; f++) begin
			for (int k = 0; k < len * nslots_i; k++) begin
				b = lsb_i ? k % len : len - 1 - k % len;
				bit1(pulse_i ? k == 0 : k >= len * nslots_i / 2, words[k / len][b]);
			end
		end
		// two idle bits, so the receiver's pipeline takes the last slot on either latch edge
		for (int k = 0; k < 2; k++) bit1(!pulse_i, data_o);
		// released data shows the inverse, never the last bit
		data_o = ~data_o;
	endtask
endmodule

//--- sim/dsc_top_asserts.sv
// concurrent checks on the top-level pins of the serial port block
`timescale 1ns/10ps
`include "dsc_map.svh"
module dsc_top_asserts #(
	parameter int BCLK_HALF = 2 // clocks per half bit
) (
	input wire logic SYS_CLK_I, // clock
	input wire logic RST_B_I, // reset
	input wire logic [7:0] WB_ADR_I, // address
	input wire logic [31:0] WB_DAT_I, // write data
	input wire logic WB_WE_I, // write
	input wire logic [3:0] WB_SEL_I, // lanes
	input wire logic WB_STB_I, // strobe
	input wire logic WB_CYC_I, // cycle
	input wire logic WB_ACK_O, // ack
	input wire logic SERIAL_BIT_CLOCK_O, // bit clock out
	input wire logic SERIAL_BIT_CLOCK_OE_O, // bit enable
	input wire logic SERIAL_FRAME_CLOCK_OE_O, // frame enable
	input wire logic PLL_LOCK_I, // lock
	input wire logic [23:0] CHAN_DATA_O, // sample
	input wire logic [2:0] CHAN_NUM_O, // channel
	input wire logic CHAN_VALID_O, // strobe
	input wire logic [7:0] CHAN_AUTOMUTED_O, // automute
	input wire logic OVERSAMPLE_128_O, // osr
	input wire logic DEEMPH_ON_O // de-emphasis
);
	logic wr;
	logic [7:0] clk_q, proc_q, mute_q;
	logic [3:0] lock_n;
	default clocking @(posedge SYS_CLK_I); endclocking
	default disable iff (!RST_B_I);
	// a write is taken only on a fresh request with lane zero
	assign wr = WB_CYC_I & WB_STB_I & WB_WE_I & ~WB_ACK_O & WB_SEL_I[0];
	// own copy of the registers, so checks never lean on the design's state
	always_ff @(posedge SYS_CLK_I) begin
		if (!RST_B_I) begin
			clk_q <= `DSC_RST_CLK;
			proc_q <= `DSC_RST_PROC;
			mute_q <= `DSC_RST_MUTE;
		end else if (wr) begin
			if (WB_ADR_I[7:2] == `DSC_IDX_CLK) clk_q <= WB_DAT_I[7:0];
			if (WB_ADR_I[7:2] == `DSC_IDX_PROC) proc_q <= WB_DAT_I[7:0];
			if (WB_ADR_I[7:2] == `DSC_IDX_MUTE) mute_q <= WB_DAT_I[7:0];
		end
	end
	// lock held long enough to cover the three stage crossing
	always_ff @(posedge SYS_CLK_I) begin
		if (!RST_B_I || !PLL_LOCK_I) lock_n <= 4'h0;
		else if (lock_n != 4'hf) lock_n <= lock_n + 4'h1;
	end
	ack_one_cycle_a: assert property (WB_ACK_O |=> !WB_ACK_O) else $error("ack longer than a cycle");
	ack_latency_a: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O) else $error("ack late");
	valid_pulse_a: assert property (CHAN_VALID_O |=> !CHAN_VALID_O) else $error("sample strobe too long");
	osr_level_a: assert property (OVERSAMPLE_128_O == proc_q[`DSC_B_OSR]) else $error("osr wrong");
	deemph_level_a: assert property (DEEMPH_ON_O == proc_q[`DSC_B_DEEMP]) else $error("deemph wrong");
	frame_drive_a: assert property (clk_q == $past(clk_q) && clk_q == $past(clk_q, 2)
		|-> SERIAL_FRAME_CLOCK_OE_O == clk_q[`DSC_B_MASTER]) else $error("frame enable wrong");
	bit_drive_a: assert property (!clk_q[`DSC_B_GEN] && clk_q == $past(clk_q, 2)
		|-> SERIAL_BIT_CLOCK_OE_O == clk_q[`DSC_B_MASTER]) else $error("bit enable wrong");
	gen_lock_a: assert property (clk_q[`DSC_B_GEN] && lock_n == 4'hf && clk_q == $past(clk_q, 2)
		|-> SERIAL_BIT_CLOCK_OE_O) else $error("bit clock not generated");
	bclk_half_a: assert property (BCLK_HALF > 1 && SERIAL_FRAME_CLOCK_OE_O && $past(SERIAL_FRAME_CLOCK_OE_O)
		&& clk_q[`DSC_B_MASTER] && $changed(SERIAL_BIT_CLOCK_O) |=> $stable(SERIAL_BIT_CLOCK_O))
		else $error("bit clock half short");
	soft_mute_a: assert property (CHAN_VALID_O && mute_q[CHAN_NUM_O] && mute_q == $past(mute_q, 8)
		|-> CHAN_DATA_O == 24'h000000) else $error("muted channel not zero");
	cover property (CHAN_VALID_O && CHAN_NUM_O == 3'h7);
	cover property (SERIAL_FRAME_CLOCK_OE_O);
	cover property (CHAN_AUTOMUTED_O == 8'h03);
endmodule
bind dsc_top dsc_top_asserts #(.BCLK_HALF(BCLK_HALF)) chk (.*);

//--- sim/dsc_top_tb.sv
// self-checking bench for the serial port block
`timescale 1ns/10ps
`include "dsc_map.svh"
`define CHECK_EQ(a, b) begin n_compared++; if ((a) !== (b)) begin bad_count++; \
	$display("unexpected at %0t got %h exp %h", $time, (a), (b)); end end
module dsc_top_tb;
	localparam int bh = 2;
	localparam logic [7:0] a_mode = {`DSC_IDX_MODE, 2'b00};
	localparam logic [7:0] a_clk = {`DSC_IDX_CLK, 2'b00};
	localparam logic [7:0] a_proc = {`DSC_IDX_PROC, 2'b00};
	localparam logic [7:0] a_mute = {`DSC_IDX_MUTE, 2'b00};
	// mode, pulse, polarity, lsb first, falling edge, 16 bit slot
	localparam logic [7:0] cases [0:5] = '{8'h00, 8'h0f, 8'h32, 8'h49, 8'h75, 8'h83};
	logic clk = 1'b0, rst_b = 1'b0, we = 1'b0, stb = 1'b0, cyc = 1'b0, lock = 1'b0;
	logic [7:0] adr = 8'h00;
	logic [31:0] wdat = 32'h0;
	logic [3:0] sel = 4'h0;
	logic fall = 1'b0, pol = 1'b0, pulse = 1'b0, lsb = 1'b0, s16 = 1'b0;
	logic [4:0] nsl = 5'd2;
	logic [31:0] rdat;
	logic ack, bo, boe, fo, foe, cval, osr, demph, hb, hf, hd;
	logic [23:0] cdat;
	logic [2:0] cnum;
	logic [7:0] amuted;
	logic [23:0] got [0:7];
	int ngot = 0, n_compared = 0, bad_count = 0;
	always #25 clk = ~clk;
	dsc_top #(.BCLK_HALF(bh)) dut (.SYS_CLK_I(clk), .RST_B_I(rst_b), .WB_ADR_I(adr), .WB_DAT_I(wdat),
		.WB_DAT_O(rdat), .WB_WE_I(we), .WB_SEL_I(sel), .WB_STB_I(stb), .WB_CYC_I(cyc), .WB_ACK_O(ack),
		.SERIAL_BIT_CLOCK_I(boe ? bo : hb), .SERIAL_BIT_CLOCK_O(bo), .SERIAL_BIT_CLOCK_OE_O(boe),
		.SERIAL_FRAME_CLOCK_I(foe ? fo : hf), .SERIAL_FRAME_CLOCK_O(fo), .SERIAL_FRAME_CLOCK_OE_O(foe),
		.SERIAL_DATA_LINE_I(hd), .PLL_LOCK_I(lock), .CHAN_DATA_O(cdat), .CHAN_NUM_O(cnum),
		.CHAN_VALID_O(cval), .CHAN_AUTOMUTED_O(amuted), .OVERSAMPLE_128_O(osr), .DEEMPH_ON_O(demph));
	dsc_host host (.bclk_o(hb), .frame_o(hf), .data_o(hd), .fall_i(fall), .pol_i(pol), .pulse_i(pulse),
		.lsb_i(lsb), .s16_i(s16), .nslots_i(nsl));
	// keep the latest sample of every channel
	always @(posedge clk) begin
		if (cval === 1'b1) begin
			got[cnum] <= cdat;
			ngot <= ngot + 1;
		end
	end
	task automatic end_sim();
		$display("compared %0d mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	// one classic cycle, held until ack is sampled high
	task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d, input logic [3:0] s,
		output logic [7:0] q);
		int i;
		@(posedge clk);
		{cyc, stb, we, adr, wdat, sel} <= {1'b1, 1'b1, w, a, 24'h0, d, s};
		i = 0;
		do begin
			@(posedge clk);
			i++;
		end while (ack !== 1'b1 && i < 50);
		q = rdat[7:0];
		{cyc, stb, we} <= 3'b000;
		if (i >= 50) begin
			bad_count++;
			end_sim();
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [7:0] q;
		wb(1'b1, a, d, 4'h1, q);
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		logic [7:0] q;
		wb(1'b0, a, 8'h00, 4'hf, q);
		`CHECK_EQ(q, e)
	endtask
	// the receiver needs link edges while reset is low
	task automatic do_reset();
		@(posedge clk);
		rst_b <= 1'b0;
		fork
			host.burst(0);
			repeat (8) @(posedge clk);
		join
		@(posedge clk);
		rst_b <= 1'b1;
	endtask
	task automatic send(input int nfr);
		ngot = 0;
		host.burst(nfr);
		repeat (20) @(posedge clk);
	endtask
	task automatic rise(output int n);
		logic p;
		n = 0;
		do begin
			p = fo;
			@(posedge clk);
			n++;
		end while (!(fo === 1'b1 && p === 1'b0) && n < 999);
		if (n >= 999) begin
			bad_count++;
			end_sim();
		end
	endtask
	task automatic t_regs();
		logic [7:0] q;
		rd(a_clk, `DSC_RST_CLK);
		rd(a_proc, `DSC_RST_PROC);
		rd(a_mute, `DSC_RST_MUTE);
		wb(1'b1, a_mute, 8'h5a, 4'h2, q);
		rd(a_mute, 8'h00);
		wr(a_mute, 8'ha5);
		rd(a_mute, 8'ha5);
		wr(8'h30, 8'hff);
		rd(8'h30, 8'h00);
		wr(a_proc, 8'h00);
		`CHECK_EQ(osr, 1'b0)
		wr(a_mute, 8'h00);
		$display("test regs done");
	endtask
	task automatic t_frames();
		logic [7:0] c;
		int n;
		for (int i = 0; i < 6; i++) begin
			c = cases[i];
			{pulse, pol, lsb, fall, s16} = c[4:0];
			nsl = c[7:5] == 3'h0 ? 5'd2 : 5'd1 << c[7:5];
			wr(a_clk, {1'b0, c[4:2], 1'b0, c[0], c[1], 1'b0});
			wr(a_proc, {3'h0, c[0], 4'h6});
			wr(a_mode, {2'h0, c[7:5], 3'h0});
			send(1);
			n = nsl > 8 ? 8 : nsl;
			`CHECK_EQ(ngot, n)
			for (int k = 0; k < n; k++) `CHECK_EQ(got[k], c[0] ? {host.words[k][15:0], 8'h00} : host.words[k][31:8])
		end
		$display("test frames done");
	endtask
	task automatic t_amute();
		host.words[0] = 32'h0;
		host.words[1] = 32'h0;
		{pulse, pol, lsb, fall, s16} = 5'b00001;
		nsl = 5'd2;
		wr(a_mode, 8'h00);
		wr(a_clk, 8'h04);
		send(1023);
		`CHECK_EQ(amuted, 8'h00)
		send(1);
		`CHECK_EQ(amuted, 8'h03)
		host.words[0] = 32'h0100;
		send(1);
		`CHECK_EQ(amuted, 8'h02)
		$display("test automute done");
	endtask
	task automatic t_proc();
		s16 = 1'b0;
		do_reset();
		host.words[0] = 32'h1000_0000;
		host.words[1] = 32'h1000_0000;
		`CHECK_EQ(osr, 1'b1)
		wr(a_proc, 8'h0f);
		wr(a_mute, 8'h02);
		send(2);
		`CHECK_EQ(demph, 1'b1)
		`CHECK_EQ(got[0], 24'hf10000)
		`CHECK_EQ(got[1], 24'h000000)
		$display("test processing done");
	endtask
	task automatic t_master();
		int n;
		wr(a_clk, 8'h01);
		rise(n);
		rise(n);
		`CHECK_EQ(n, 128 * bh)
		`CHECK_EQ({boe, foe}, 2'b11)
		wr(a_clk, 8'h05);
		rise(n);
		rise(n);
		`CHECK_EQ(n, 64 * bh)
		wr(a_clk, 8'h80);
		lock <= 1'b1;
		repeat (16) @(posedge clk);
		`CHECK_EQ({boe, foe}, 2'b10)
		wr(a_clk, 8'h00);
		lock <= 1'b0;
		repeat (8) @(posedge clk);
		`CHECK_EQ({boe, foe}, 2'b00)
		$display("test master done");
	endtask
	initial begin
		for (int s = 0; s < 16; s++) host.words[s] = 32'h13579bdf ^ (s * 32'h11111111);
		do_reset();
		t_regs();
		t_frames();
		t_amute();
		t_proc();
		t_master();
		end_sim();
	end
endmodule
